// ===== src/remote_io_pkg.sv
/*
  Constants and types for the remote I/O mode and bit-order block.
  Assumes a 100 MHz system clock.
*/
package remote_io_pkg;
  localparam int          CLOCK_HZ        = 100_000_000;
  localparam int          SETUP_BAUD      = 115_200;
  localparam int          OPERATE_BAUD    = 2_500_000;
  localparam int          SETUP_DIV       = CLOCK_HZ / SETUP_BAUD;
  localparam int          OPERATE_DIV     = CLOCK_HZ / OPERATE_BAUD;
  localparam int          DIV_W           = 16;
  localparam int          IO_BITS         = 48;
  localparam int          GROUP_BITS      = 24;
  localparam int          STRAP_DELAY     = 4;
  localparam logic [47:0] OUT_RESET       = 48'h0;
  localparam logic [2:0]  CNT_RESET       = 3'h0;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN   = 2'b10
  } cfg_state_t;
endpackage : remote_io_pkg

// ===== src/sync3.sv
/*
  Three-stage synchroniser with agreement filter on the last two stages.
  Assumes asynchronous input and a single clock.
*/
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         clock,   // System clock
  input  wire logic         sys_rst, // Async reset, high
  input  wire logic [W-1:0] d,       // Async input
  output logic      [W-1:0] q        // Filtered output
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else if (s2_q == s3_q)
      q <= s3_q;
  end
endmodule : sync3

// ===== src/remote_io_cfg.sv
/*
  Mode and bit-order configuration with the 48-bit open-drain I/O path.
  Assumes straps are static pins and the serial core uses baud_div.
*/
`timescale 1ns/1ps
module remote_io_cfg
  import remote_io_pkg::*;
#(
  parameter int NBITS = IO_BITS
) (
  input  wire logic             clock,             // System clock
  input  wire logic             sys_rst,           // Async reset, high
  input  wire logic             mode_select_strap, // 1 = up = operate
  input  wire logic             pin_order_strap,   // 1 = up = descending
  input  wire logic             rate_wr,           // Rate write strobe
  input  wire logic [DIV_W-1:0] rate_div,          // New operate divisor
  input  wire logic [NBITS-1:0] host_out,          // Host output bits
  input  wire logic [NBITS-1:0] pin_in,            // Pin levels
  output logic      [NBITS-1:0] host_in,           // Host input bits
  output logic      [NBITS-1:0] pin_oe,            // Drive low enable
  output logic      [NBITS-1:0] pin_out,           // Pin drive value
  output logic                  operate_mode,      // Operate mode active
  output logic                  descending,        // Descending order
  output logic      [DIV_W-1:0] baud_div,          // Clocks per bit
  output logic                  cfg_ready          // Straps latched
);
  localparam logic [DIV_W-1:0] SETUP_DIV_W   = DIV_W'(SETUP_DIV);
  localparam logic [DIV_W-1:0] OPERATE_DIV_W = DIV_W'(OPERATE_DIV);
  localparam logic [2:0]       DELAY_W       = 3'(STRAP_DELAY);

  cfg_state_t       state_q;
  logic [2:0]       cnt_q;
  logic [1:0]       strap_s;
  logic [NBITS-1:0] pin_s;
  logic [DIV_W-1:0] op_div_q;

  // Reverse within each group when descending
  function automatic logic [NBITS-1:0] reorder(input logic [NBITS-1:0] v,
                                                input logic rev);
    logic [NBITS-1:0] r;
    r = v;
    if (rev)
      for (int i = 0; i < NBITS; i++)
        r[i] = v[(i / GROUP_BITS) * GROUP_BITS + GROUP_BITS - 1 - (i % GROUP_BITS)];
    return r;
  endfunction : reorder

  sync3 #(.W(2)) u_strap_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({mode_select_strap, pin_order_strap}),
    .q       (strap_s)
  );

  sync3 #(.W(NBITS)) u_pin_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       (pin_in),
    .q       (pin_s)
  );

  // Wait for synchroniser to settle, latch once, then hold
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_WAIT;
      cnt_q   <= CNT_RESET;
    end
    else
    begin
      case (state_q)
        ST_WAIT:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == DELAY_W)
            state_q <= ST_LATCH;
        end
        ST_LATCH: state_q <= ST_RUN;
        ST_RUN:   state_q <= ST_RUN;
        default:  state_q <= ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      operate_mode <= 1'b0;
      descending   <= 1'b0;
      cfg_ready    <= 1'b0;
    end
    else if (state_q == ST_LATCH)
    begin
      operate_mode <= strap_s[1];
      descending   <= strap_s[0];
      cfg_ready    <= 1'b1;
    end
  end

  // Operate divisor: default 2.5 Mbaud, writable only in operate mode
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      op_div_q <= OPERATE_DIV_W;
    else if (rate_wr && operate_mode && cfg_ready && rate_div != '0)
      op_div_q <= rate_div;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      baud_div <= SETUP_DIV_W;
    else
      baud_div <= operate_mode ? op_div_q : SETUP_DIV_W;
  end

  // Pin path: inverted, reordered, open drain
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_oe  <= OUT_RESET;
      pin_out <= OUT_RESET;
      host_in <= OUT_RESET;
    end
    else
    begin
      pin_oe  <= reorder(host_out, descending);
      pin_out <= OUT_RESET;
      host_in <= reorder(~pin_s, descending);
    end
  end

  a_strap_hold: assert property (@(posedge clock) disable iff (sys_rst)
    cfg_ready |=> $stable(operate_mode) && $stable(descending))
    else $error("strap mode changed after latch");

  a_setup_rate: assert property (@(posedge clock) disable iff (sys_rst)
    (cfg_ready && !operate_mode) |=> baud_div == SETUP_DIV_W)
    else $error("setup mode rate not fixed");

  a_rate_write: assert property (@(posedge clock) disable iff (sys_rst)
    (rate_wr && operate_mode && cfg_ready && rate_div != '0) |=> ##1 baud_div == $past(rate_div, 2))
    else $error("operate rate not updated");

  a_mode_sel: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_LATCH |=> operate_mode == $past(strap_s[1]))
    else $error("mode strap not honoured");

  a_order_sel: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_LATCH |=> descending == $past(strap_s[0]))
    else $error("order strap not honoured");

  a_drive_map: assert property (@(posedge clock) disable iff (sys_rst)
    descending && $stable(descending) |=> pin_oe[0] == $past(host_out[GROUP_BITS-1])
      && pin_oe[GROUP_BITS] == $past(host_out[NBITS-1]))
    else $error("descending map wrong");

  a_asc_map: assert property (@(posedge clock) disable iff (sys_rst)
    !descending && $stable(descending) |=> pin_oe == $past(host_out))
    else $error("ascending map wrong");

  a_read_inv: assert property (@(posedge clock) disable iff (sys_rst)
    !descending && $stable(descending) |=> host_in == ~$past(pin_s))
    else $error("input not inverted");

  a_no_high_drive: assert property (@(posedge clock) disable iff (sys_rst)
    pin_out == '0)
    else $error("pin driven high");

  // Rate write accepted: operate mode, latched, nonzero divisor
  sequence s_rate_take;
    rate_wr && operate_mode && cfg_ready && rate_div != '0;
  endsequence : s_rate_take

  // Rate write that must be dropped
  sequence s_rate_skip;
    rate_wr && !(operate_mode && cfg_ready && rate_div != '0);
  endsequence : s_rate_skip

  // Settle counter expires, latch state follows
  sequence s_settle_done;
    state_q == ST_WAIT && cnt_q == DELAY_W ##1 state_q == ST_LATCH;
  endsequence : s_settle_done

  // Divisor register and link rate
  a_rate_taken: assert property (@(posedge clock) disable iff (sys_rst)
    s_rate_take |=> op_div_q == $past(rate_div))
    else $error("accepted rate not stored");

  a_rate_refused: assert property (@(posedge clock) disable iff (sys_rst)
    s_rate_skip |=> $stable(op_div_q))
    else $error("refused rate write stored");

  a_default_rate: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(operate_mode) |=> baud_div == OPERATE_DIV_W)
    else $error("operate default rate wrong");

  // Strap latch sequence
  a_ready_latch: assert property (@(posedge clock) disable iff (sys_rst)
    s_settle_done |=> cfg_ready && state_q == ST_RUN)
    else $error("straps not latched after settle");

  // Group ends and input side of the reversal
  a_group_ends: assert property (@(posedge clock) disable iff (sys_rst)
    descending && $stable(descending) |=> pin_oe[GROUP_BITS-1] == $past(host_out[0])
      && pin_oe[NBITS-1] == $past(host_out[GROUP_BITS]))
    else $error("group reversal wrong");

  a_read_desc: assert property (@(posedge clock) disable iff (sys_rst)
    descending && $stable(descending) |=> host_in[0] == !$past(pin_s[GROUP_BITS-1]))
    else $error("descending input map wrong");

  // Host zero leaves every pin released
  a_release: assert property (@(posedge clock) disable iff (sys_rst)
    host_out == '0 |=> pin_oe == '0)
    else $error("released bit still sunk");
endmodule : remote_io_cfg

// ===== bench/pin_side_model.sv
/*
  Pin-side model: pull-ups and external switches on the open-drain bits.
  Assumes pin_oe high means the device sinks the pin.
*/
`timescale 1ns/1ps
module pin_side_model (
  input  wire logic [47:0] pin_oe,  // Device sink enable
  input  wire logic [47:0] pin_out, // Device drive value
  input  wire logic [47:0] ext_low, // External switch closed
  output logic      [47:0] pin_lvl  // Resolved pin level
);
  // Pull-up only wins when nobody sinks the line
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule : pin_side_model

// ===== bench/tb.sv
/*
  Self-checking bench for the mode, rate and bit-order block.
  Assumes a 100 MHz clock and the pin-side model on the pins.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb;
  import remote_io_pkg::*;
  logic        clock = 1'b0, sys_rst = 1'b1, rate_wr = 1'b0;
  logic        mode_select_strap = 1'b0, pin_order_strap = 1'b0;
  logic [15:0] rate_div = 16'h0000;
  logic [47:0] host_out = 48'h0, ext_low = 48'h0;
  logic [47:0] host_in, pin_oe, pin_out, pin_lvl;
  logic [15:0] baud_div;
  logic        operate_mode, descending, cfg_ready;
  int          mismatches = 0, total_checks = 0, cycles = 0;

  remote_io_cfg i_dut (.clock(clock), .sys_rst(sys_rst), .mode_select_strap(mode_select_strap),
    .pin_order_strap(pin_order_strap), .rate_wr(rate_wr), .rate_div(rate_div),
    .host_out(host_out), .pin_in(pin_lvl), .host_in(host_in), .pin_oe(pin_oe),
    .pin_out(pin_out), .operate_mode(operate_mode), .descending(descending),
    .baud_div(baud_div), .cfg_ready(cfg_ready));
  pin_side_model i_pins (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low),
    .pin_lvl(pin_lvl));

  always #5 clock = ~clock;

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Reset with chosen straps, then wait for the latch
  task start(input logic m, input logic o);
    @(negedge clock);
    sys_rst = 1'b1;
    mode_select_strap = m;
    pin_order_strap = o;
    host_out = 48'h0;
    ext_low = 48'h0;
    repeat (5) @(negedge clock);
    `CHK("baud_rst", 16'h0364, baud_div)
    `CHK("oe_rst", 48'h0, pin_oe)
    sys_rst = 1'b0;
    for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) @(negedge clock);
    `CHK("ready", 1'b1, cfg_ready)
    `CHK("mode", m, operate_mode)
    `CHK("order", o, descending)
    repeat (5) @(negedge clock);
  endtask : start

  task wr_rate(input logic [15:0] d);
    rate_wr = 1'b1;
    rate_div = d;
    @(negedge clock);
    rate_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask : wr_rate

  task drive(input logic [47:0] h, input logic [47:0] e);
    host_out = h;
    ext_low = e;
    repeat (8) @(negedge clock);
  endtask : drive

  task t_setup;
    start(1'b0, 1'b0);
    wr_rate(16'h0064);
    `CHK("setup_baud", 16'h0364, baud_div)
  endtask : t_setup

  task t_operate;
    start(1'b1, 1'b0);
    `CHK("op_baud", 16'h0028, baud_div)
    wr_rate(16'h0000);
    `CHK("div0", 16'h0028, baud_div)
    wr_rate(16'h0064);
    `CHK("new_baud", 16'h0064, baud_div)
    drive(48'h800000000001, 48'h0);
    `CHK("oe_asc", 48'h800000000001, pin_oe)
    `CHK("drv_val", 48'h0, pin_out)
    `CHK("drv_rd", 48'h800000000001, host_in)
    drive(48'h0, 48'h000001000002);
    `CHK("in_asc", 48'h000001000002, host_in)
    mode_select_strap = 1'b0;
    pin_order_strap = 1'b1;
    repeat (10) @(negedge clock);
    `CHK("mode_hold", 1'b1, operate_mode)
    `CHK("order_hold", 1'b0, descending)
  endtask : t_operate

  task t_desc;
    start(1'b1, 1'b1);
    drive(48'h000001000001, 48'h0);
    `CHK("oe_desc", 48'h800000800000, pin_oe)
    drive(48'h0, 48'h000000800002);
    `CHK("in_desc", 48'h000000400001, host_in)
  endtask : t_desc

  initial
  begin
    t_setup();
    t_operate();
    t_desc();
    print_verdict();
  end
endmodule : tb
